// ==== hw/assd_defines.svh ====
// register offsets, flag layout and timing counts of the serial block
`ifndef ASSD_DEFINES_SVH
`define ASSD_DEFINES_SVH
`define ASSD_OFS_STATUS 8'h0c
`define ASSD_OFS_DATA 8'h0e
`define ASSD_STAT_RST 9'h180
`define ASSD_RX_ACK_MASK 9'h05f
`define ASSD_TX_ACK_MASK 9'h180
`define ASSD_TICK_LAST 4'hf
`define ASSD_SMP_A 4'h7
`define ASSD_SMP_B 4'h8
`define ASSD_SMP_C 4'h9
`define ASSD_IDLE_LIM8 8'h9f
`define ASSD_IDLE_LIM9 8'haf
`define ASSD_BITS8 4'h8
`define ASSD_BITS9 4'h9
`define ASSD_FRAME_EXTRA 4'h2
`endif

// ==== hw/assd_pkg.sv ====
// shared types of the serial status and data block
`default_nettype none
package assd_pkg;
   // status flags, msb first as they sit in the status register
   typedef struct packed {
      logic tx_holding_empty_flag;
      logic tc;
      logic rx_holding_full_flag;
      logic rx_active_flag;
      logic idle;
      logic ovr;
      logic nf;
      logic fe;
      logic pf;
   } assd_stat_t;
   typedef struct packed {
      logic te;
      logic re;
      logic m;
      logic pe;
      logic pt;
      logic idle_detect_type;
      logic rx_wakeup_mode;
      logic sbk;
      logic tx_empty_int_en;
      logic tx_done_int_en;
      logic rx_full_int_en;
      logic line_quiet_int_en;
   } assd_ctrl_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [15:0] wdata;
   } assd_req_t;
   typedef enum logic [1:0] {rx_idle, rx_start, rx_data, rx_stop} assd_rx_t;
   typedef enum logic {tx_idle, tx_shift} assd_tx_t;
endpackage
`default_nettype wire

// ==== hw/assd_top.sv ====
// serial status flags, data register, bit-level transmitter and receiver
`include "assd_defines.svh"
`default_nettype none
module assd_top (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   // register port
   input wire assd_pkg::assd_req_t req,
   output logic [15:0] rdata,
   // configuration and 16x bit-rate tick
   input wire assd_pkg::assd_ctrl_t ctrl,
   input wire logic os_tick,
   // serial line and interrupt
   input wire logic rxd,
   output logic txd,
   output logic irq
);
   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   function automatic logic [10:0] tx_word(input logic [8:0] d,
                                           input assd_pkg::assd_ctrl_t c);
      logic [8:0] w;
      w = d;
      if (c.pe && c.m) w[8] = (^d[7:0]) ^ c.pt;
      if (c.pe && !c.m) w[7] = (^d[6:0]) ^ c.pt;
      if (!c.m) w[8] = 1'b1;
      return {1'b1, w, 1'b0};
   endfunction

   logic st_rd, dt_rd, dt_wr;
   assign st_rd = ce & req.rd & hit(req.addr, `ASSD_OFS_STATUS);
   assign dt_rd = ce & req.rd & hit(req.addr, `ASSD_OFS_DATA);
   assign dt_wr = ce & req.wr & hit(req.addr, `ASSD_OFS_DATA);

   assd_pkg::assd_stat_t serial_status_reg, ack_arm_reg, set_v, clr_v;
   assd_pkg::assd_stat_t serial_status_next;
   assd_pkg::assd_rx_t rx_state_reg;
   assd_pkg::assd_tx_t tx_state_reg;
   logic [8:0] rx_holding_reg, tx_holding_reg, rx_shift_reg;
   logic rx_s1_reg, rx_s2_reg, rx_s3_reg, rx_line_reg;
   logic [3:0] rx_tick_reg, rx_bit_reg, tx_tick_reg, tx_left_reg, nbits;
   logic smp_a_reg, smp_b_reg, rx_noise_reg;
   logic [7:0] idle_cnt_reg, idle_lim;
   logic idle_done_reg, idle_ok_reg;
   logic [10:0] tx_frame_reg;
   logic maj, dis, eval, start_det, frame_end, rx_ok, rx_xfer, rx_ovr;
   logic par_bad, idle_ev, tx_load, brk_load, tx_done;

   // ------------------------------------------------------------
   // receive line synchroniser
   // ------------------------------------------------------------
   // line level only moves when the last two stages agree
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
         rx_s3_reg <= 1'b1;
         rx_line_reg <= 1'b1;
      end else if (ce) begin
         rx_s1_reg <= rxd;
         rx_s2_reg <= rx_s1_reg;
         rx_s3_reg <= rx_s2_reg;
         if (rx_s2_reg == rx_s3_reg) rx_line_reg <= rx_s3_reg;
      end
   end

   // ------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------
   assign nbits = ctrl.m ? `ASSD_BITS9 : `ASSD_BITS8;
   assign maj = (smp_a_reg & smp_b_reg) | (smp_a_reg & rx_line_reg) |
                (smp_b_reg & rx_line_reg);
   assign dis = ~(smp_a_reg == smp_b_reg && smp_b_reg == rx_line_reg);
   assign eval = ce & os_tick & (rx_tick_reg == `ASSD_SMP_C) &
                 (rx_state_reg != assd_pkg::rx_idle);
   assign start_det = ce & os_tick & (rx_state_reg == assd_pkg::rx_idle) &
                      ~rx_line_reg & ctrl.re;
   assign frame_end = eval & (rx_state_reg == assd_pkg::rx_stop);
   // wakeup mode swallows the word without touching any flag
   assign rx_ok = frame_end & ~ctrl.rx_wakeup_mode;
   assign rx_xfer = rx_ok & ~serial_status_reg.rx_holding_full_flag &
                    ~serial_status_reg.ovr;
   assign rx_ovr = rx_ok & ~rx_xfer;
   assign par_bad = ctrl.pe &
                    ((^(rx_shift_reg & {ctrl.m, 8'hff})) ^ ctrl.pt);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rx_state_reg <= assd_pkg::rx_idle;
         rx_tick_reg <= 4'h0;
         rx_bit_reg <= 4'h0;
         smp_a_reg <= 1'b1;
         smp_b_reg <= 1'b1;
         rx_noise_reg <= 1'b0;
         rx_shift_reg <= 9'h000;
      end else if (ce && os_tick) begin
         rx_tick_reg <= (rx_state_reg == assd_pkg::rx_idle) ? 4'h1 :
                        rx_tick_reg + 4'h1;
         if (rx_tick_reg == `ASSD_SMP_A) smp_a_reg <= rx_line_reg;
         if (rx_tick_reg == `ASSD_SMP_B) smp_b_reg <= rx_line_reg;
         unique case (rx_state_reg)
            assd_pkg::rx_idle: begin
               if (start_det) rx_state_reg <= assd_pkg::rx_start;
            end
            assd_pkg::rx_start: begin
               // a start that votes high is dropped with no noise
               if (eval && maj) rx_state_reg <= assd_pkg::rx_idle;
               if (eval) rx_noise_reg <= dis;
               if (rx_tick_reg == `ASSD_TICK_LAST) begin
                  rx_state_reg <= assd_pkg::rx_data;
                  rx_bit_reg <= 4'h0;
               end
            end
            assd_pkg::rx_data: begin
               if (eval) begin
                  rx_shift_reg[rx_bit_reg] <= maj;
                  rx_noise_reg <= rx_noise_reg | dis;
               end
               if (rx_tick_reg == `ASSD_TICK_LAST) begin
                  rx_bit_reg <= rx_bit_reg + 4'h1;
                  if (rx_bit_reg == nbits - 4'h1)
                     rx_state_reg <= assd_pkg::rx_stop;
               end
            end
            assd_pkg::rx_stop: begin
               // leave at mid stop so the next start edge is caught
               if (eval) rx_state_reg <= assd_pkg::rx_idle;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) rx_holding_reg <= 9'h000;
      else if (rx_xfer) rx_holding_reg <= rx_shift_reg;
   end

   // ------------------------------------------------------------
   // idle line detection
   // ------------------------------------------------------------
   assign idle_lim = ctrl.m ? `ASSD_IDLE_LIM9 : `ASSD_IDLE_LIM8;
   assign idle_ev = ce & os_tick & rx_line_reg & ~idle_done_reg &
                    (idle_cnt_reg == idle_lim) &
                    (~ctrl.idle_detect_type | (rx_state_reg == assd_pkg::rx_idle));

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         idle_cnt_reg <= 8'h00;
         idle_done_reg <= 1'b0;
      end else if (ce) begin
         // long type clears the count while a frame is in flight
         if (!rx_line_reg ||
             (ctrl.idle_detect_type && rx_state_reg != assd_pkg::rx_idle)) begin
            idle_cnt_reg <= 8'h00;
            idle_done_reg <= 1'b0;
         end else if (idle_ev) idle_done_reg <= 1'b1;
         else if (os_tick && !idle_done_reg)
            idle_cnt_reg <= idle_cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) idle_ok_reg <= 1'b1;
      else if (set_v.idle) idle_ok_reg <= 1'b0;
      else if (rx_xfer) idle_ok_reg <= 1'b1;
   end

   // ------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------
   assign tx_load = ce & os_tick & (tx_state_reg == assd_pkg::tx_idle) &
                    ctrl.te & ~ctrl.sbk & ~serial_status_reg.tx_holding_empty_flag;
   assign brk_load = ce & os_tick & (tx_state_reg == assd_pkg::tx_idle) &
                     ctrl.te & ctrl.sbk;
   assign tx_done = ce & os_tick & (tx_state_reg == assd_pkg::tx_shift) &
                    (tx_tick_reg == `ASSD_TICK_LAST) & (tx_left_reg == 4'h1);

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) tx_holding_reg <= 9'h000;
      else if (dt_wr) tx_holding_reg <= req.wdata[8:0];
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tx_state_reg <= assd_pkg::tx_idle;
         tx_frame_reg <= 11'h7ff;
         tx_left_reg <= 4'h0;
         tx_tick_reg <= 4'h0;
      end else if (ce && os_tick) begin
         unique case (tx_state_reg)
            assd_pkg::tx_idle: begin
               if (tx_load || brk_load) begin
                  // a break frame is all zeros, stop bit included
                  tx_frame_reg <= brk_load ? 11'h000 :
                                  tx_word(tx_holding_reg, ctrl);
                  tx_left_reg <= nbits + `ASSD_FRAME_EXTRA;
                  tx_tick_reg <= 4'h0;
                  tx_state_reg <= assd_pkg::tx_shift;
               end
            end
            assd_pkg::tx_shift: begin
               tx_tick_reg <= tx_tick_reg + 4'h1;
               if (tx_tick_reg == `ASSD_TICK_LAST) begin
                  tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
                  tx_left_reg <= tx_left_reg - 4'h1;
                  if (tx_left_reg == 4'h1) tx_state_reg <= assd_pkg::tx_idle;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) txd <= 1'b1;
      else if (ce) txd <= (tx_state_reg == assd_pkg::tx_shift) ?
                          tx_frame_reg[0] : 1'b1;
   end

   // ------------------------------------------------------------
   // status flags and acknowledge sequence
   // ------------------------------------------------------------
   always_comb begin
      set_v = '0;
      set_v.tx_holding_empty_flag = tx_load;
      set_v.tc = tx_done & serial_status_reg.tx_holding_empty_flag & ~ctrl.sbk;
      set_v.rx_holding_full_flag = rx_xfer;
      set_v.nf = rx_xfer & (rx_noise_reg | dis);
      set_v.fe = rx_xfer & ~maj;
      set_v.pf = rx_xfer & par_bad;
      set_v.ovr = rx_ovr;
      set_v.idle = idle_ev & idle_ok_reg & ~ctrl.rx_wakeup_mode;
      set_v.rx_active_flag = start_det & ~ctrl.rx_wakeup_mode;
      // only flags seen by the status read are cleared
      clr_v = ack_arm_reg &
              ((dt_rd ? `ASSD_RX_ACK_MASK : 9'h000) |
               (dt_wr ? `ASSD_TX_ACK_MASK : 9'h000));
      // a new event wins over a clear in the same cycle
      serial_status_next = (serial_status_reg & ~clr_v) | set_v;
      serial_status_next.rx_active_flag = set_v.rx_active_flag |
                               (serial_status_reg.rx_active_flag & ~idle_ev);
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) serial_status_reg <= `ASSD_STAT_RST;
      else if (ce) serial_status_reg <= serial_status_next;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) ack_arm_reg <= '0;
      else if (st_rd) ack_arm_reg <= serial_status_reg;
      else if (dt_rd || dt_wr) ack_arm_reg <= ack_arm_reg & ~clr_v;
   end

   // ------------------------------------------------------------
   // read data and interrupt
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) rdata <= 16'h0000;
      else if (st_rd) rdata <= {7'h00, serial_status_reg};
      else if (dt_rd) rdata <= {7'h00, ctrl.m & rx_holding_reg[8],
                                rx_holding_reg[7:0]};
      else if (ce && req.rd) rdata <= 16'h0000;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) irq <= 1'b0;
      else if (ce) irq <= (serial_status_reg.tx_holding_empty_flag & ctrl.tx_empty_int_en) |
                          (serial_status_reg.tc & ctrl.tx_done_int_en) |
                          (~ctrl.rx_wakeup_mode & ((serial_status_reg.rx_holding_full_flag & ctrl.rx_full_int_en) |
                           (serial_status_reg.idle & ctrl.line_quiet_int_en)));
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   sequence s_ack_rx;
      st_rd && serial_status_reg.rx_holding_full_flag ##1 (!dt_rd) [*2] ##1
         dt_rd && !rx_xfer;
   endsequence
   property p_tx_holding_empty_flag_on_load;
      tx_load |=> serial_status_reg.tx_holding_empty_flag;
   endproperty
   a_tx_holding_empty_flag_on_load: assert property (p_tx_holding_empty_flag_on_load)
      else $error("holding-empty not set on load");
   property p_unacked_write;
      dt_wr && serial_status_reg.tx_holding_empty_flag && !ack_arm_reg.tx_holding_empty_flag |=>
         serial_status_reg.tx_holding_empty_flag;
   endproperty
   a_unacked_write: assert property (p_unacked_write)
      else $error("unacknowledged write cleared holding-empty");
   property p_err_with_full;
      $rose(serial_status_reg.fe) || $rose(serial_status_reg.nf) ||
         $rose(serial_status_reg.pf) |-> $past(rx_xfer);
   endproperty
   a_err_with_full: assert property (p_err_with_full)
      else $error("error flag set without a transfer");
   property p_ovr_keeps;
      rx_ovr |=> $stable(rx_holding_reg) && serial_status_reg.ovr;
   endproperty
   a_ovr_keeps: assert property (p_ovr_keeps)
      else $error("overrun changed holding data");
   property p_no_idle_wake;
      $rose(serial_status_reg.idle) |-> $past(!ctrl.rx_wakeup_mode && idle_ok_reg);
   endproperty
   a_no_idle_wake: assert property (p_no_idle_wake)
      else $error("idle set in wakeup or before new data");
   property p_ack_rx;
      s_ack_rx |=> !serial_status_reg.rx_holding_full_flag;
   endproperty
   a_ack_rx: assert property (p_ack_rx)
      else $error("receive-full not cleared by acknowledge");
   property p_stop_zero;
      rx_xfer && !maj |=> serial_status_reg.fe && serial_status_reg.rx_holding_full_flag;
   endproperty
   a_stop_zero: assert property (p_stop_zero)
      else $error("zero stop bit gave no framing fault");
   property p_raf_start;
      start_det && !ctrl.rx_wakeup_mode |=> serial_status_reg.rx_active_flag ##1 1'b1;
   endproperty
   a_raf_start: assert property (p_raf_start)
      else $error("receiver-active not set on start");
endmodule // assd_top
`default_nettype wire

// ==== verification/assd_far_end.sv ====
// remote serial transceiver model facing the block's serial lines
`default_nettype none
module assd_far_end (
   // clock and bit-rate tick
   input wire logic mclk,
   input wire logic os_tick,
   // frame length and serial lines
   input wire logic nine,
   input wire logic txd,
   output var logic rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // line driver and frame catcher
   // ----------------------------------------
   logic [9:0] caught[$];
   initial rxd = 1'b1;
   task automatic tick_wait(input int n);
      for (int i = 0; i < n; i++) begin
         do @(posedge mclk); while (os_tick !== 1'b1);
      end
   endtask
   // glitch is one tick wide at mid bit: it hits a single vote whatever
   // the receiver's start offset, so the majority still holds
   task automatic send(input logic [8:0] dat, input logic stop_v,
         input int glitch);
      logic [10:0] bits;
      bits = nine ? {stop_v, dat, 1'b0} : {1'b1, stop_v, dat[7:0], 1'b0};
      tick_wait(1);
      for (int b = 0; b < (nine ? 11 : 10); b++) begin
         rxd <= bits[b];
         tick_wait(9);
         if (b == glitch) rxd <= ~bits[b];
         tick_wait(1);
         if (b == glitch) rxd <= bits[b];
         tick_wait(6);
      end
      rxd <= 1'b1;
   endtask
   // samples the block's output at mid bit, as a remote receiver would
   initial begin
      logic [9:0] w;
      int n;
      forever begin
         tick_wait(1);
         if (txd === 1'b0) begin
            tick_wait(8);
            w = '0;
            n = nine ? 10 : 9;
            for (int b = 0; b < n; b++) begin
               tick_wait(16);
               w[b] = txd;
            end
            caught.push_back(nine ? w : {w[8], 1'b0, w[7:0]});
         end
      end
   end
endmodule // assd_far_end
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench of the serial status and data block
`include "assd_defines.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1;
   logic os_tick = 1'b0;
   logic [1:0] tick_cnt = 2'h0;
   logic rxd;
   logic txd;
   logic irq;
   logic [15:0] rdata;
   logic [15:0] d;
   assd_pkg::assd_req_t req = '0;
   assd_pkg::assd_ctrl_t ctrl = 12'hc00;
   int n_mismatch = 0;
   int tests_run = 0;
   logic [8:0] tx_q[$];
   logic [15:0] exp_st[5] = '{16'h01e4, 16'h01e2, 16'h01e2, 16'h01e1,
      16'h01e0};

   assd_top u_dut (.mclk(mclk), .arst_n(arst_n), .ce(ce), .req(req),
      .rdata(rdata), .ctrl(ctrl), .os_tick(os_tick), .rxd(rxd),
      .txd(txd), .irq(irq));
   assd_far_end u_far (.mclk(mclk), .os_tick(os_tick), .nine(ctrl.m),
      .txd(txd), .rxd(rxd));

   always #2.5 mclk = ~mclk;
   // tick every fourth clock keeps frames short
   always @(posedge mclk) begin
      tick_cnt <= tick_cnt + 2'h1;
      os_tick <= (tick_cnt == 2'h3);
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic access(input logic rd, input logic [7:0] a,
         input logic [15:0] wd);
      @(posedge mclk);
      req <= '{rd: rd, wr: ~rd, addr: a, wdata: wd};
      @(posedge mclk);
      req <= '0;
      @(posedge mclk);
      #1 d = rdata;
   endtask
   task automatic rd_status();
      access(1'b1, `ASSD_OFS_STATUS, 16'h0);
   endtask
   task automatic rd_data();
      access(1'b1, `ASSD_OFS_DATA, 16'h0);
   endtask
   task automatic settle();
      repeat (800) @(posedge mclk);
      rd_status();
      rd_data();
   endtask
   task automatic wait_caught();
      for (int i = 0; i < 4000 && u_far.caught.size() == 0; i++)
         @(posedge mclk);
      if (u_far.caught.size() == 0) begin
         n_mismatch++;
         give_verdict();
      end
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] a;
      logic [7:0] b;
      logic [8:0] v;
      void'($urandom(24081));
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      access(1'b0, `ASSD_OFS_DATA, 16'h00a5);
      repeat (900) @(posedge mclk);
      chk(16'(u_far.caught.size()), 16'h0);
      rd_status();
      // idle line after reset reports once before any word arrives
      chk(d, 16'h0190);
      rd_data();
      access(1'b1, 8'h20, 16'h0);
      chk(d, 16'h0);
      @(posedge mclk) ctrl.te <= 1'b0;
      a = 8'($urandom);
      b = 8'($urandom);
      access(1'b0, `ASSD_OFS_DATA, {8'h0, a});
      access(1'b0, `ASSD_OFS_DATA, {8'h0, b});
      tx_q.push_back({1'b0, b});
      rd_status();
      chk(d, 16'h0000);
      @(posedge mclk) ctrl.te <= 1'b1;
      repeat (40) @(posedge mclk);
      rd_status();
      chk(d, 16'h0100);
      wait_caught();
      chk({6'h0, u_far.caught.pop_front()}, {6'h0, 1'b1, tx_q.pop_front()});
      repeat (64) @(posedge mclk);
      rd_status();
      chk(d, 16'h0180);
      for (int j = 0; j < 3; j++) begin
         @(posedge mclk) ctrl.tx_empty_int_en <= (j == 0);
         ctrl.tx_done_int_en <= (j == 1);
         repeat (3) @(posedge mclk);
         chk({15'h0, irq}, {15'h0, j < 2});
      end
      // receive path, interrupt on full holding register
      @(posedge mclk) ctrl.rx_full_int_en <= 1'b1;
      ctrl.line_quiet_int_en <= 1'b1;
      a = 8'($urandom);
      u_far.send({1'b0, a}, 1'b1, -1);
      repeat (4) @(posedge mclk);
      chk({15'h0, irq}, 16'h1);
      rd_status();
      chk(d, 16'h01e0);
      rd_data();
      chk(d, {8'h0, a});
      rd_status();
      chk(d, 16'h01a0);
      repeat (800) @(posedge mclk);
      rd_status();
      chk(d, 16'h0190);
      chk({15'h0, irq}, 16'h1);
      settle();
      rd_status();
      chk(d, 16'h0180);
      // frozen block ignores the data read, read data holds
      @(posedge mclk) ce <= 1'b0;
      rd_data();
      chk(d, 16'h0180);
      @(posedge mclk) ce <= 1'b1;
      // noise, framing, break, bad even parity, good odd parity
      for (int k = 0; k < 5; k++) begin
         a = (k == 2) ? 8'h00 : 8'($urandom);
         if (k > 2) a[7] = ~^a[6:0];
         @(posedge mclk) ctrl.pe <= (k > 2);
         ctrl.pt <= (k == 4);
         u_far.send({1'b0, a}, (k == 1 || k == 2) ? 1'b0 : 1'b1,
            (k == 0) ? 3 : -1);
         rd_status();
         chk(d, exp_st[k]);
         rd_data();
         chk(d & 16'h007f, {9'h0, a[6:0]});
         settle();
      end
      @(posedge mclk) ctrl.pe <= 1'b0;
      a = 8'($urandom);
      b = 8'($urandom);
      u_far.send({1'b0, a}, 1'b1, -1);
      u_far.send({1'b0, b}, 1'b1, -1);
      rd_status();
      chk(d, 16'h01e8);
      rd_data();
      chk(d, {8'h0, a});
      settle();
      // wakeup mode hides the word and every receiver flag
      @(posedge mclk) ctrl.rx_wakeup_mode <= 1'b1;
      u_far.send({1'b0, b}, 1'b1, -1);
      repeat (800) @(posedge mclk);
      rd_status();
      chk(d, 16'h0180);
      chk({15'h0, irq}, 16'h0);
      @(posedge mclk) ctrl.rx_wakeup_mode <= 1'b0;
      ctrl.m <= 1'b1;
      ctrl.idle_detect_type <= 1'b1;
      v = 9'($urandom);
      u_far.send(v, 1'b1, -1);
      rd_status();
      chk(d, 16'h01e0);
      rd_data();
      chk(d, {7'h0, v});
      // long idle type counts only from mid stop bit, once the receiver is idle
      repeat (800) @(posedge mclk);
      rd_status();
      chk(d, 16'h0190);
      // break frames are all zeros, stop bit included
      @(posedge mclk) ctrl.sbk <= 1'b1;
      wait_caught();
      chk({6'h0, u_far.caught.pop_front()}, 16'h0000);
      @(posedge mclk) ctrl.sbk <= 1'b0;
      give_verdict();
   end
endmodule // tb
`default_nettype wire
